// ### hw/sats_sequencer.sv
`timescale 1ns/100ps
`default_nettype none
module sats_sequencer
  import sats_pkg::*;
#(
  parameter int CONV_CYC = SATS_CONV_CYC
)(
  // Clock and reset
  input  wire logic        aclk,
  input  wire logic        aresetn,
  // AXI4-Lite write address
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  // AXI4-Lite write data
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  // AXI4-Lite write response
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  // AXI4-Lite read address
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  // AXI4-Lite read data
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  // Trigger event sources, one pulse line per source code
  input  wire logic [31:0] trig_src_in,
  // Analog front end
  output logic [7:0]       pos_sel_onehot,
  output logic             mux_connect,
  output logic             neg_diff,
  output logic             scale_signed,
  output logic             sampling,
  output logic             converting,
  input  wire logic [11:0] conv_data,
  // Pins shared with the converter
  input  wire logic [7:0]  pin_in,
  output logic [7:0]       analog_pin_select
);

  typedef enum logic [1:0]
  {
    SATS_IDLE   = 2'b00,
    SATS_SAMPLE = 2'b01,
    SATS_CONV   = 2'b10
  } sats_state_e;

  //////////////////////////////////////////////////////////////////////////////
  // Registers

  logic [31:0]      converter_control_one_r;
  logic [31:0]      converter_control_two_r;
  logic [7:0]       scan_select_reg_r;
  logic [15:0]      input_mode_reg_r;
  logic [29:0]      input_trigger_select_reg_r;
  logic [31:0]      result_r;
  logic [2:0]       last_ch_r;
  logic             done_r;
  logic [31:0]      trig_q1_r;
  logic [31:0]      trig_q2_r;
  logic [31:0]      trig_q3_r;
  logic [31:0]      trig_stable_r;
  logic [7:0]       pin_q1_r;
  logic [7:0]       pin_q2_r;
  logic [7:0]       pin_q3_r;
  logic [7:0]       pin_stable_r;
  logic [7:0]       ind_pend_r;
  logic [7:0]       scan_pend_r;
  logic [7:0]       ind_pend_nxt;
  logic [7:0]       scan_pend_nxt;
  sats_state_e      state_r;
  logic [2:0]       cur_ch_r;
  logic             cur_scan_r;
  logic [15:0]      cnt_r;
  logic [31:0]      trig_evt;
  logic [7:0]       ind_hit;
  logic [7:0]       pend_all;
  logic [2:0]       pick_ch;
  logic             pick_scan;
  logic             scan_hit;
  logic             sw_trig;
  logic [9:0]       sample_time_field;
  logic [4:0]       scan_src;
  logic             conv_on;

  // Lowest set bit wins: natural priority
  function automatic logic [2:0] sats_lowest(input logic [7:0] v);
    logic [2:0] idx;
    idx = 3'd0;
    for (int i = SATS_NUM_IN - 1; i >= 0; i--)
    begin
      if (v[i])
        idx = 3'(i);
    end
    return idx;
  endfunction

  function automatic logic [4:0] sats_src(input logic [29:0] r, input int ch);
    return r[ch*SATS_SRC_W +: SATS_SRC_W];
  endfunction

  assign sample_time_field     = converter_control_two_r[SATS_SAMPLE_TIME_FIELD_LSB +: 10];
  assign scan_src = converter_control_one_r[SATS_STRG_LSB +: 5];
  assign conv_on  = converter_control_one_r[SATS_ON_BIT];

  //////////////////////////////////////////////////////////////////////////////
  // AXI4-Lite slave, one write and one read at a time

  logic aw_hold_r;
  logic w_hold_r;
  logic [7:0]  awaddr_r;
  logic [31:0] wdata_r;
  logic [3:0]  wstrb_r;
  logic        wr_go;
  logic        wr_ok;

  assign s_axi_awready = !aw_hold_r && !s_axi_bvalid;
  assign s_axi_wready  = !w_hold_r && !s_axi_bvalid;
  assign wr_go         = aw_hold_r && w_hold_r && !s_axi_bvalid;
  assign s_axi_arready = !s_axi_rvalid;
  assign sw_trig       = wr_go && awaddr_r == SATS_OFF_SWTRG && wstrb_r[0] && wdata_r[0];

  always_comb
  begin
    case (awaddr_r)
      SATS_OFF_CTRL1, SATS_OFF_CTRL2, SATS_OFF_SCAN, SATS_OFF_MODE,
      SATS_OFF_TRG0, SATS_OFF_TRG1, SATS_OFF_ANSEL, SATS_OFF_SWTRG: wr_ok = 1'b1;
      default: wr_ok = 1'b0;
    endcase
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_hold_r    <= 1'b0;
      w_hold_r     <= 1'b0;
      awaddr_r     <= 8'h00;
      wdata_r      <= 32'h0000_0000;
      wstrb_r      <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= SATS_RESP_OKAY;
    end
    else
    begin
      if (s_axi_awvalid && s_axi_awready)
      begin
        aw_hold_r <= 1'b1;
        awaddr_r  <= {s_axi_awaddr[7:2], 2'b00};
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
        w_hold_r <= 1'b1;
        wdata_r  <= s_axi_wdata;
        wstrb_r  <= s_axi_wstrb;
      end
      if (wr_go)
      begin
        aw_hold_r    <= 1'b0;
        w_hold_r     <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= wr_ok ? SATS_RESP_OKAY : SATS_RESP_SLVERR;
      end
      else if (s_axi_bready)
        s_axi_bvalid <= 1'b0;
    end
  end

  function automatic logic [31:0] sats_merge(input logic [31:0] o, input logic [31:0] n,
                                             input logic [3:0] s);
    logic [31:0] r;
    r = o;
    for (int b = 0; b < 4; b++)
    begin
      if (s[b])
        r[b*8 +: 8] = n[b*8 +: 8];
    end
    return r;
  endfunction

  // Byte lane mask and masked data of the pending write
  logic [31:0] wr_mask;
  logic [31:0] wr_dm;

  assign wr_mask = sats_merge(32'h0000_0000, 32'hFFFF_FFFF, wstrb_r);
  assign wr_dm   = wdata_r & wr_mask;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      converter_control_one_r    <= SATS_CTRL1_RST;
      converter_control_two_r    <= SATS_CTRL2_RST;
      scan_select_reg_r          <= 8'h00;
      input_mode_reg_r           <= 16'h0000;
      input_trigger_select_reg_r <= 30'h0000_0000;
      analog_pin_select          <= SATS_ANSEL_RST;
    end
    else if (wr_go)
    begin
      case (awaddr_r)
        SATS_OFF_CTRL1: converter_control_one_r <= sats_merge(converter_control_one_r,
                                                              wdata_r, wstrb_r);
        SATS_OFF_CTRL2: converter_control_two_r <= sats_merge(converter_control_two_r,
                                                              wdata_r, wstrb_r);
        SATS_OFF_SCAN:  scan_select_reg_r <= (scan_select_reg_r & ~wr_mask[7:0]) | wr_dm[7:0];
        SATS_OFF_MODE:  input_mode_reg_r <= (input_mode_reg_r & ~wr_mask[15:0]) | wr_dm[15:0];
        SATS_OFF_TRG0:  input_trigger_select_reg_r[14:0] <= {wr_dm[20:16], wr_dm[12:8],
                                                              wr_dm[4:0]};
        SATS_OFF_TRG1:  input_trigger_select_reg_r[29:15] <= {wr_dm[20:16], wr_dm[12:8],
                                                               wr_dm[4:0]};
        SATS_OFF_ANSEL: analog_pin_select <= (analog_pin_select & ~wr_mask[7:0]) | wr_dm[7:0];
        default: ;
      endcase
    end
  end

  // Read path; reading the result clears the done flag
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h0000_0000;
      s_axi_rresp  <= SATS_RESP_OKAY;
    end
    else if (s_axi_arvalid && s_axi_arready)
    begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp  <= SATS_RESP_OKAY;
      case ({s_axi_araddr[7:2], 2'b00})
        SATS_OFF_CTRL1:  s_axi_rdata <= converter_control_one_r;
        SATS_OFF_CTRL2:  s_axi_rdata <= converter_control_two_r;
        SATS_OFF_SCAN:   s_axi_rdata <= {24'h0, scan_select_reg_r};
        SATS_OFF_MODE:   s_axi_rdata <= {16'h0, input_mode_reg_r};
        SATS_OFF_TRG0:   s_axi_rdata <= {11'h0, input_trigger_select_reg_r[14:10], 3'h0,
                                         input_trigger_select_reg_r[9:5], 3'h0,
                                         input_trigger_select_reg_r[4:0]};
        SATS_OFF_TRG1:   s_axi_rdata <= {11'h0, input_trigger_select_reg_r[29:25], 3'h0,
                                         input_trigger_select_reg_r[24:20], 3'h0,
                                         input_trigger_select_reg_r[19:15]};
        SATS_OFF_ANSEL:  s_axi_rdata <= {24'h0, analog_pin_select};
        SATS_OFF_PORT:   s_axi_rdata <= {24'h0, pin_stable_r & ~analog_pin_select};
        SATS_OFF_STAT:   s_axi_rdata <= {16'h0, ind_pend_r | scan_pend_r, 2'b0, done_r,
                                         last_ch_r, state_r};
        SATS_OFF_RESULT: s_axi_rdata <= result_r;
        SATS_OFF_SWTRG:  s_axi_rdata <= 32'h0000_0000;
        default:
        begin
          s_axi_rdata <= 32'h0000_0000;
          s_axi_rresp <= SATS_RESP_SLVERR;
        end
      endcase
    end
    else if (s_axi_rready)
      s_axi_rvalid <= 1'b0;
  end

  //////////////////////////////////////////////////////////////////////////////
  // Trigger and pin synchronisers; rising edge on agreement of stages 2 and 3

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      trig_q1_r    <= 32'h0000_0000;
      trig_q2_r    <= 32'h0000_0000;
      trig_q3_r    <= 32'h0000_0000;
      trig_stable_r <= 32'h0000_0000;
      pin_q1_r     <= 8'h00;
      pin_q2_r     <= 8'h00;
      pin_q3_r     <= 8'h00;
      pin_stable_r <= 8'h00;
    end
    else
    begin
      trig_q1_r <= trig_src_in;
      trig_q2_r <= trig_q1_r;
      trig_q3_r <= trig_q2_r;
      // Stages 2 and 3 agreeing set the settled level
      trig_stable_r <= (trig_stable_r & (trig_q2_r ^ trig_q3_r))
                     | (trig_q3_r & ~(trig_q2_r ^ trig_q3_r));
      pin_q1_r  <= pin_in;
      pin_q2_r  <= pin_q1_r;
      pin_q3_r  <= pin_q2_r;
      for (int i = 0; i < SATS_NUM_IN; i++)
      begin
        if (pin_q2_r[i] == pin_q3_r[i])
          pin_stable_r[i] <= pin_q3_r[i];
      end
    end
  end

  always_comb
  begin
    trig_evt = trig_q2_r & trig_q3_r & ~trig_stable_r;
    trig_evt[SATS_SRC_SW] = trig_evt[SATS_SRC_SW] | sw_trig;
    trig_evt[SATS_SRC_NONE] = 1'b0;
  end

  assign scan_hit = conv_on && trig_evt[scan_src];

  // Per-input triggers; class split 0-5 versus 6-7
  always_comb
  begin
    ind_hit = 8'h00;
    for (int i = 0; i < SATS_NUM_IND; i++)
    begin
      if (conv_on && sats_src(input_trigger_select_reg_r, i) != SATS_SRC_SCAN)
        ind_hit[i] = trig_evt[sats_src(input_trigger_select_reg_r, i)];
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Pending sets and arbitration

  assign pend_all  = ind_pend_r | scan_pend_r;
  assign pick_ch   = sats_lowest(pend_all);
  assign pick_scan = !ind_pend_r[pick_ch];

  always_comb
  begin
    ind_pend_nxt  = ind_pend_r | ind_hit;
    scan_pend_nxt = scan_pend_r;
    if (scan_hit)
    begin
      for (int i = 0; i < SATS_NUM_IN; i++)
      begin
        if (scan_select_reg_r[i] && (i >= SATS_NUM_IND ||
            sats_src(input_trigger_select_reg_r, i) == SATS_SRC_SCAN))
          scan_pend_nxt[i] = 1'b1;
      end
    end
    if (state_r == SATS_IDLE && pend_all != 8'h00)
    begin
      // New hits may set the same bit again in the same cycle
      ind_pend_nxt[pick_ch]  = ind_hit[pick_ch];
      scan_pend_nxt[pick_ch] = scan_hit && scan_pend_nxt[pick_ch] && pick_scan ?
                               1'b1 : (pick_scan ? 1'b0 : scan_pend_nxt[pick_ch]);
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Sample and convert sequence

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      state_r     <= SATS_IDLE;
      cur_ch_r    <= 3'd0;
      cur_scan_r  <= 1'b0;
      cnt_r       <= 16'h0000;
      ind_pend_r  <= 8'h00;
      scan_pend_r <= 8'h00;
    end
    else
    begin
      ind_pend_r  <= ind_pend_nxt;
      scan_pend_r <= scan_pend_nxt;
      case (state_r)
        SATS_IDLE:
        begin
          // Scan bits not taken stay pending, so a preempted scan resumes
          if (pend_all != 8'h00)
          begin
            state_r    <= SATS_SAMPLE;
            cur_ch_r   <= pick_ch;
            cur_scan_r <= pick_scan;
            cnt_r      <= {6'h00, sample_time_field};
          end
        end
        SATS_SAMPLE:
        begin
          // Other triggers only queue while busy
          if (cnt_r <= 16'h0001)
          begin
            state_r <= SATS_CONV;
            cnt_r   <= 16'(CONV_CYC);
          end
          else
            cnt_r <= cnt_r - 16'h0001;
        end
        SATS_CONV:
        begin
          if (cnt_r <= 16'h0001)
            state_r <= SATS_IDLE;
          else
            cnt_r <= cnt_r - 16'h0001;
        end
        default: state_r <= SATS_IDLE;
      endcase
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Front end control and result

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      pos_sel_onehot <= 8'h00;
      mux_connect    <= 1'b0;
      neg_diff       <= 1'b0;
      scale_signed   <= 1'b0;
      sampling       <= 1'b0;
      converting     <= 1'b0;
    end
    else
    begin
      mux_connect    <= state_r != SATS_IDLE;
      pos_sel_onehot <= state_r != SATS_IDLE ? 8'h01 << cur_ch_r : 8'h00;
      neg_diff       <= state_r != SATS_IDLE && input_mode_reg_r[2*cur_ch_r + 1];
      scale_signed   <= state_r != SATS_IDLE && input_mode_reg_r[2*cur_ch_r];
      sampling       <= state_r == SATS_SAMPLE;
      converting     <= state_r == SATS_CONV;
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      result_r  <= 32'h0000_0000;
      last_ch_r <= 3'd0;
      done_r    <= 1'b0;
    end
    else if (state_r == SATS_CONV && cnt_r <= 16'h0001)
    begin
      last_ch_r <= cur_ch_r;
      done_r    <= 1'b1;
      if (converter_control_one_r[SATS_FRACT_BIT])
        result_r <= {(input_mode_reg_r[2*cur_ch_r] ? {~conv_data[11], conv_data[10:0]}
                      : conv_data), 20'h00000};
      else if (input_mode_reg_r[2*cur_ch_r])
        result_r <= 32'(signed'({~conv_data[11], conv_data[10:0]}));
      else
        result_r <= {20'h00000, conv_data};
    end
    else if (s_axi_arvalid && s_axi_arready && {s_axi_araddr[7:2], 2'b00} == SATS_OFF_RESULT)
      done_r <= 1'b0;
  end

endmodule
`default_nettype wire

// ### hw/sats_pkg.sv
// Function
// - Inputs 0-5 individual, 6-7 scan only
// - Individual inputs: own trigger or scan
// - Scan-only inputs converted on scan trigger
// - Trigger starts sampling for sample time
// - After conversion serve next pending input
// - Idle with nothing pending disconnects converter
// - New trigger waits for current cycle
// - Simultaneous triggers: lowest input first
// - Common sample time, per-input trigger source
// - Scan includes only selected inputs
// - Scan choice or scan source triggers scan
// - Scan runs in ascending input order
// - Higher priority trigger preempts running scan
// - Positive input follows selected input
// - Negative input per differential bit
// - Signed bit alone sets scaling
// - Analog select bits reset to analog
// - Analog pins read zero from port
// - Integer right, fractional left justified
package sats_pkg;
  localparam int          SATS_NUM_IN      = 8;
  localparam int          SATS_NUM_IND     = 6;
  localparam logic [7:0]  SATS_OFF_CTRL1   = 8'h00;
  localparam logic [7:0]  SATS_OFF_CTRL2   = 8'h04;
  localparam logic [7:0]  SATS_OFF_SCAN    = 8'h08;
  localparam logic [7:0]  SATS_OFF_MODE    = 8'h0C;
  localparam logic [7:0]  SATS_OFF_TRG0    = 8'h10;
  localparam logic [7:0]  SATS_OFF_TRG1    = 8'h14;
  localparam logic [7:0]  SATS_OFF_ANSEL   = 8'h18;
  localparam logic [7:0]  SATS_OFF_PORT    = 8'h1C;
  localparam logic [7:0]  SATS_OFF_STAT    = 8'h20;
  localparam logic [7:0]  SATS_OFF_RESULT  = 8'h24;
  localparam logic [7:0]  SATS_OFF_SWTRG   = 8'h28;
  localparam int          SATS_STRG_LSB    = 16;
  localparam int          SATS_FRACT_BIT   = 23;
  localparam int          SATS_ON_BIT      = 15;
  localparam int          SATS_SAMPLE_TIME_FIELD_LSB    = 16;
  localparam int          SATS_SRC_W       = 5;
  localparam logic [4:0]  SATS_SRC_NONE    = 5'h00;
  localparam logic [4:0]  SATS_SRC_SCAN    = 5'h03;
  localparam logic [4:0]  SATS_SRC_SW      = 5'h01;
  localparam int          SATS_CONV_CYC    = 13;
  localparam logic [31:0] SATS_CTRL1_RST   = 32'h0000_0000;
  localparam logic [31:0] SATS_CTRL2_RST   = 32'h0001_0000;
  localparam logic [7:0]  SATS_ANSEL_RST   = 8'hFF;
  localparam logic [1:0]  SATS_RESP_OKAY   = 2'b00;
  localparam logic [1:0]  SATS_RESP_SLVERR = 2'b10;
endpackage

// ### dv/sats_seq_assertions.sv
`timescale 1ns/100ps
`default_nettype none
module sats_seq_assertions
  import sats_pkg::*;
#(
  parameter int CONV_CYC = SATS_CONV_CYC
)(
  // Clock and reset
  input  wire logic       aclk,
  input  wire logic       aresetn,
  // Read address and data
  input  wire logic       s_axi_arvalid,
  input  wire logic       s_axi_arready,
  input  wire logic       s_axi_rvalid,
  // Front end
  input  wire logic [7:0] pos_sel_onehot,
  input  wire logic       mux_connect,
  input  wire logic       sampling,
  input  wire logic       converting,
  input  wire logic [7:0] analog_pin_select
);
  logic [15:0] conv_cnt_r;

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  // Length of the running conversion
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      conv_cnt_r <= 16'h0000;
    else
      conv_cnt_r <= converting ? conv_cnt_r + 16'h0001 : 16'h0000;
  end

  ////////////////////////////////////////////////////////////
  a_pos_onehot: assert property ($onehot0(pos_sel_onehot))
    else $error("positive select not one-hot");
  a_idle_open: assert property (!mux_connect |-> pos_sel_onehot == 8'h00)
    else $error("input selected while disconnected");
  a_samp_conn: assert property (sampling |-> mux_connect && pos_sel_onehot != 8'h00)
    else $error("sampling without a connected input");
  a_phase_excl: assert property (!(sampling && converting))
    else $error("sampling and converting together");
  a_samp_conv: assert property ($fell(sampling) |-> converting)
    else $error("conversion did not follow sampling");
  a_conv_cause: assert property ($rose(converting) |-> $past(sampling))
    else $error("conversion started without sampling");
  a_conv_len: assert property ($fell(converting) |-> conv_cnt_r == 16'(CONV_CYC))
    else $error("conversion length wrong");
  a_chan_hold: assert property ((sampling || converting) && !$rose(sampling)
    |-> $stable(pos_sel_onehot))
    else $error("input changed during a cycle");
  a_ansel_rst: assert property ($rose(aresetn) |-> analog_pin_select == SATS_ANSEL_RST)
    else $error("pins not analog after reset");
  a_rd_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");

  c_conv: cover property ($rose(converting));
  c_chan_two: cover property (sampling && pos_sel_onehot == 8'h04);
  c_scan_only: cover property (sampling && pos_sel_onehot[7]);
endmodule

bind sats_sequencer sats_seq_assertions #(.CONV_CYC(CONV_CYC)) u_sats_chk (
  .aclk(aclk), .aresetn(aresetn), .s_axi_arvalid(s_axi_arvalid),
  .s_axi_arready(s_axi_arready), .s_axi_rvalid(s_axi_rvalid),
  .pos_sel_onehot(pos_sel_onehot), .mux_connect(mux_connect), .sampling(sampling),
  .converting(converting), .analog_pin_select(analog_pin_select)
);
`default_nettype wire

// ### dv/sats_front_model.sv
`timescale 1ns/100ps
`default_nettype none
module sats_front_model (
  // Clock
  input  wire logic        aclk,
  // Converter side
  input  wire logic [7:0]  pos_sel_onehot,
  input  wire logic        converting,
  output logic [11:0]      conv_data
);
  initial conv_data = 12'h000;

  // Channel code while converting, toggling garbage otherwise
  always @(posedge aclk)
    conv_data <= converting ? {3'($clog2(pos_sel_onehot)), 9'h0A5} : ~conv_data;
endmodule
`default_nettype wire

// ### dv/testbench.sv
`timescale 1ns/100ps
`default_nettype none
module testbench;
  import sats_pkg::*;
  localparam int CONV = 6;
  logic        aclk = 1'b0;
  logic        aresetn, awvalid, wvalid, arvalid, bready, rready;
  logic        awready, wready, bvalid, arready, rvalid;
  logic        mux, neg, sgn, samp, conv, sp;
  logic [1:0]  bresp, rresp;
  logic [7:0]  awaddr, araddr, pos, pin, ansel;
  logic [11:0] cdata;
  logic [31:0] wdata, rdata, trig, mode, rs;
  logic [34:0] re;
  int          n_errors, checks, sample_time_field, slen, ch;
  logic [34:0] rq[$];
  logic [1:0]  bq[$];
  int          chq[$];

  always #5 aclk = ~aclk;

  sats_sequencer #(.CONV_CYC(CONV)) uut (
    .aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .trig_src_in(trig), .pos_sel_onehot(pos), .mux_connect(mux), .neg_diff(neg),
    .scale_signed(sgn), .sampling(samp), .converting(conv), .conv_data(cdata),
    .pin_in(pin), .analog_pin_select(ansel)
  );

  sats_front_model u_fe (
    .aclk(aclk), .pos_sel_onehot(pos), .converting(conv), .conv_data(cdata)
  );

  ////////////////////////////////////////////////////////////
  function automatic logic [31:0] rnd();
    rs = rs ^ (rs << 13);
    rs = rs ^ (rs >> 17);
    rs = rs ^ (rs << 5);
    return rs;
  endfunction

  // Channel 0 result for signed s, fractional f
  function automatic logic [31:0] fmt(logic s, logic f);
    logic [11:0] x;
    x = s ? 12'h8A5 : 12'h0A5;
    return f ? {x, 20'h00000} : s ? {{20{x[11]}}, x} : {20'h00000, x};
  endfunction

  task automatic chk(string nm, logic [34:0] e, logic [34:0] g);
    checks++;
    if (g !== e)
    begin
      n_errors++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic tally_and_finish();
    if (n_errors == 0 && checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  task automatic wr(logic [7:0] a, logic [31:0] d, logic [1:0] r = SATS_RESP_OKAY);
    bq.push_back(r);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    forever
    begin
      @(posedge aclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
      if (bvalid) break;
    end
  endtask

  // Expected read: {response only, resp, data}
  task automatic rd(logic [7:0] a, logic [34:0] e);
    rq.push_back(e);
    araddr <= a;
    arvalid <= 1'b1;
    forever
    begin
      @(posedge aclk);
      if (arready) arvalid <= 1'b0;
      if (rvalid) break;
    end
  endtask

  task automatic pulse(int c);
    trig[c] <= 1'b1;
    repeat (3) @(posedge aclk);
    trig[c] <= 1'b0;
  endtask

  // Quiet for three edges: one idle cycle between inputs is not the end
  task automatic idle();
    int q;
    q = 0;
    repeat (8) @(posedge aclk);
    while (q < 3)
    begin
      @(posedge aclk);
      q = (mux || samp || conv) ? 0 : q + 1;
    end
  endtask

  ////////////////////////////////////////////////////////////
  always @(posedge aclk)
  begin
    if (bvalid && bready)
      chk("bresp", 35'(bq.pop_front()), 35'(bresp));
    if (rvalid && rready)
    begin
      re = rq.pop_front();
      chk("read", re, {re[34], rresp, re[34] ? 32'h0 : rdata});
    end
    if (samp && !sp)
    begin
      ch = $clog2(pos);
      chk("chan", 35'(chq.pop_front()), 35'(ch));
      chk("mode", 35'(mode[2*ch +: 2]), 35'({neg, sgn}));
    end
    if (samp)
      slen++;
    else if (sp)
    begin
      chk("samp_len", 35'(sample_time_field > 0 ? sample_time_field : 1), 35'(slen));
      slen = 0;
    end
    sp = samp;
  end

  initial
  begin
    repeat (5000) @(posedge aclk);
    n_errors++;
    tally_and_finish();
  end

  initial
  begin
    {aresetn, awvalid, wvalid, arvalid, sp} = '0;
    {bready, rready} = 2'b11;
    {awaddr, araddr, wdata, trig, mode} = '0;
    {n_errors, checks, sample_time_field, slen} = '0;
    rs = 32'h0399EDC5;
    pin <= 8'(rnd());
    repeat (8) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    chk("ansel", 35'(SATS_ANSEL_RST), 35'(ansel));
    rd(SATS_OFF_CTRL2, {3'b000, SATS_CTRL2_RST});
    rd(SATS_OFF_PORT, 35'h0);
    wr(SATS_OFF_ANSEL, 32'h0000000F);
    rd(SATS_OFF_PORT, {27'h0, pin & 8'hF0});
    rd(8'h3C, {1'b1, SATS_RESP_SLVERR, 32'h0});
    wr(8'h3C, 32'h0, SATS_RESP_SLVERR);
    mode = rnd();
    sample_time_field = int'(rnd() % 6);
    wr(SATS_OFF_MODE, mode);
    wr(SATS_OFF_CTRL2, 32'(sample_time_field) << SATS_SAMPLE_TIME_FIELD_LSB);
    wr(SATS_OFF_TRG0, 32'h00070700);
    wr(SATS_OFF_TRG1, 32'h00030307);
    wr(SATS_OFF_CTRL1, 32'h00098000);
    // Inputs 1..3 fired together
    chq = '{1, 2, 3};
    pulse(7);
    idle();
    // Scan of 4, 6, 7
    wr(SATS_OFF_SCAN, 32'h000000D0);
    chq = '{4, 6, 7};
    pulse(9);
    idle();
    // Input 2 breaks into a scan of 5, 7
    wr(SATS_OFF_TRG0, 32'h000B0701);
    wr(SATS_OFF_SCAN, 32'h000000A0);
    chq = '{5, 2, 7};
    pulse(9);
    while (pos !== 8'h20) @(posedge aclk);
    pulse(11);
    idle();
    // Result formats on a software trigger of input 0
    for (int i = 0; i < 4; i++)
    begin
      mode[0] = i[1];
      wr(SATS_OFF_MODE, mode);
      wr(SATS_OFF_CTRL1, 32'h00098000 | (32'(i[0]) << SATS_FRACT_BIT));
      chq.push_back(0);
      wr(SATS_OFF_SWTRG, 32'h00000001);
      idle();
      rd(SATS_OFF_STAT, 35'h20);
      rd(SATS_OFF_RESULT, {3'b000, fmt(i[1], i[0])});
    end
    rd(SATS_OFF_STAT, 35'h0);
    chk("pending", 35'h0, 35'(chq.size()));
    tally_and_finish();
  end
endmodule
`default_nettype wire
